// File: logic/serial_host_pins.sv
`timescale 1ns/100ps
// Dual-channel host pin block: interrupt pin, DMA acknowledge port and alternate clock pins.
module serial_host_pins
#(
    parameter logic [3:0] VERSION_CODE = 4'h1
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    output logic             int_req_n_out,
    output logic             int_req_n_oe,
    input  wire logic [6:0]  host_addr,
    input  wire logic        host_cs_n,
    input  wire logic        host_rd_n,
    input  wire logic        host_wr_n,
    input  wire logic [7:0]  host_data_in,
    output logic [7:0]       host_data_out,
    output logic             host_data_oe,
    input  wire logic        dma_grant_n_chan_a,
    input  wire logic        dma_grant_n_chan_b,
    input  wire logic [1:0]  alt_clock_input,
    output logic [1:0]       rx_dma_request,
    output logic [1:0]       tx_dma_request,
    output logic [1:0]       xtal_osc_en,
    input  wire logic [15:0] rx_data,
    input  wire logic [1:0]  rx_valid,
    output logic [1:0]       rx_ready,
    output logic [15:0]      tx_data,
    output logic [1:0]       tx_valid,
    input  wire logic [1:0]  tx_ready
);
    logic             ack_r;
    logic             req;
    logic             wr_go;
    logic [7:0]       wbyte;
    logic [7:0]       rd_val;
    logic [7:0]       irq_status_reg;
    logic [7:0]       irq_mask_r;
    logic [7:0]       extended_irq_reg;
    logic [7:0]       ext_mask_r;
    logic [1:0][7:0]  clk_mode_r;
    logic [1:0][7:0]  tx_byte_count_high_reg;
    logic [7:0]       version_status_reg;
    logic [7:0]       ev_status;
    logic [7:0]       ev_ext;
    logic             irq_pending;
    logic [1:0][7:0]  rx_head_w;
    logic [1:0][5:0]  events_w;
    logic [1:0]       cd_level_w;
    logic [1:0]       rx_en_w;
    logic [1:0]       pop_w;
    logic [1:0]       push_w;
    logic             rd_q_r;
    logic             wr_q_r;
    logic             grant_any;
    logic             sel_chan;
    logic             sel_ok;
    logic             rd_fall;
    logic             wr_rise;
    logic             wr_chan_r;
    logic             wr_ok_r;
    logic [7:0]       wr_data_r;

    // One wait cycle on every access keeps read data registered.
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign wr_go           = avs_write && ack_r && avs_byteenable[0];
    assign wbyte           = avs_writedata[7:0];

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= req && !ack_r;
    end

    always_comb
    begin
        unique case (avs_address)
            hp_pkg::OFF_IRQ_STATUS: rd_val = irq_status_reg;
            hp_pkg::OFF_IRQ_MASK:   rd_val = irq_mask_r;
            hp_pkg::OFF_EXT_IRQ:    rd_val = extended_irq_reg;
            hp_pkg::OFF_EXT_MASK:   rd_val = ext_mask_r;
            hp_pkg::OFF_CLK_MODE_A: rd_val = clk_mode_r[0];
            hp_pkg::OFF_CLK_MODE_B: rd_val = clk_mode_r[1];
            hp_pkg::OFF_TXBC_HI_A:  rd_val = tx_byte_count_high_reg[0];
            hp_pkg::OFF_TXBC_HI_B:  rd_val = tx_byte_count_high_reg[1];
            hp_pkg::OFF_VER_STATUS: rd_val = version_status_reg;
            default:                rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !ack_r)
            avs_readdata <= {24'h00_0000, rd_val};
    end

    assign version_status_reg = {VERSION_CODE, rx_en_w, cd_level_w};

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_r <= hp_pkg::MASK_RESET;
            ext_mask_r <= hp_pkg::MASK_RESET;
        end
        else if (wr_go)
        begin
            if (avs_address == hp_pkg::OFF_IRQ_MASK)
                irq_mask_r <= wbyte;
            if (avs_address == hp_pkg::OFF_EXT_MASK)
                ext_mask_r <= wbyte;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            clk_mode_r             <= {2{hp_pkg::CLK_MODE_RESET}};
            tx_byte_count_high_reg <= {2{hp_pkg::TXBC_HI_RESET}};
        end
        else if (wr_go)
        begin
            if (avs_address == hp_pkg::OFF_CLK_MODE_A)
                clk_mode_r[0] <= wbyte;
            if (avs_address == hp_pkg::OFF_CLK_MODE_B)
                clk_mode_r[1] <= wbyte;
            if (avs_address == hp_pkg::OFF_TXBC_HI_A)
                tx_byte_count_high_reg[0] <= wbyte;
            if (avs_address == hp_pkg::OFF_TXBC_HI_B)
                tx_byte_count_high_reg[1] <= wbyte;
        end
    end

    // A new event wins over a write-one clear in the same cycle.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_status_reg   <= 8'h00;
            extended_irq_reg <= 8'h00;
        end
        else
        begin
            if (wr_go && avs_address == hp_pkg::OFF_IRQ_STATUS)
                irq_status_reg <= (irq_status_reg & ~wbyte) | ev_status;
            else
                irq_status_reg <= irq_status_reg | ev_status;
            if (wr_go && avs_address == hp_pkg::OFF_EXT_IRQ)
                extended_irq_reg <= (extended_irq_reg & ~wbyte) | ev_ext;
            else
                extended_irq_reg <= extended_irq_reg | ev_ext;
        end
    end

    assign irq_pending = |(irq_status_reg & irq_mask_r) || |(extended_irq_reg & ext_mask_r);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= irq_pending;
    end

    assign int_req_n_out = 1'b0;
    assign int_req_n_oe  = irq;

    assign grant_any = !dma_grant_n_chan_a || !dma_grant_n_chan_b;
    assign sel_chan  = grant_any ? dma_grant_n_chan_a : host_addr[hp_pkg::PIN_CHAN_BIT];
    assign sel_ok    = grant_any || (!host_cs_n && !host_addr[hp_pkg::PIN_WIN_BIT]);
    assign rd_fall   = rd_q_r && !host_rd_n;
    assign wr_rise   = !wr_q_r && host_wr_n;

    // Drive the data pins only for a selected read, never for a foreign one.
    assign host_data_oe = !host_rd_n && sel_ok;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_q_r <= 1'b1;
            wr_q_r <= 1'b1;
        end
        else
        begin
            rd_q_r <= host_rd_n;
            wr_q_r <= host_wr_n;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            host_data_out <= 8'h00;
        else if (rd_fall)
            host_data_out <= sel_ok ? rx_head_w[sel_chan] : 8'h00;
    end

    // Write data is caught while the strobe is low and pushed at its rising edge.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wr_chan_r <= 1'b0;
            wr_ok_r   <= 1'b0;
            wr_data_r <= 8'h00;
        end
        else if (!host_wr_n)
        begin
            wr_chan_r <= sel_chan;
            wr_ok_r   <= sel_ok;
            wr_data_r <= host_data_in;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_chan
            assign pop_w[g]  = rd_fall && sel_ok && sel_chan == 1'(g);
            assign push_w[g] = wr_rise && wr_ok_r && wr_chan_r == 1'(g);

            assign ev_status[hp_pkg::IRQ_RX_BLOCK + g]   = events_w[g][0];
            assign ev_status[hp_pkg::IRQ_TX_SPACE + g]   = events_w[g][1];
            assign ev_status[hp_pkg::IRQ_CD_CHANGE + g]  = events_w[g][2];
            assign ev_status[hp_pkg::IRQ_FRAME_SYNC + g] = events_w[g][3];
            assign ev_ext[hp_pkg::EXT_RX_OVF + g]        = events_w[g][4];
            assign ev_ext[hp_pkg::EXT_TX_OVF + g]        = events_w[g][5];

            chan_fifo_port
            #(
                .IS_CHAN_A (g == 0)
            )
            u_chan
            (
                .mclk            (mclk),
                .rst             (rst),
                .clock_mode      (clk_mode_r[g][hp_pkg::MODE_LSB +: 3]),
                .block_sel       (clk_mode_r[g][hp_pkg::BLK_SEL_LSB +: 2]),
                .auto_start      (tx_byte_count_high_reg[g][hp_pkg::AUTO_START_BIT]),
                .alt_clock_input (alt_clock_input[g]),
                .rx_data         (rx_data[8*g +: 8]),
                .rx_valid        (rx_valid[g]),
                .rx_ready        (rx_ready[g]),
                .tx_data         (tx_data[8*g +: 8]),
                .tx_valid        (tx_valid[g]),
                .tx_ready        (tx_ready[g]),
                .pop             (pop_w[g]),
                .push            (push_w[g]),
                .push_data       (wr_data_r),
                .rx_head         (rx_head_w[g]),
                .rx_dma_request  (rx_dma_request[g]),
                .tx_dma_request  (tx_dma_request[g]),
                .cd_level        (cd_level_w[g]),
                .rx_enabled      (rx_en_w[g]),
                .xtal_osc        (xtal_osc_en[g]),
                .events          (events_w[g])
            );
        end
    endgenerate
endmodule : serial_host_pins

// File: logic/hp_pkg.sv
// Constants shared by the host pin block and its channel module.
package hp_pkg;
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_W      = 6;
    localparam int IDX_W      = 5;
    localparam int ADDR_W     = 8;

    localparam logic [7:0] OFF_IRQ_STATUS = 8'h00;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h04;
    localparam logic [7:0] OFF_EXT_IRQ    = 8'h08;
    localparam logic [7:0] OFF_EXT_MASK   = 8'h0c;
    localparam logic [7:0] OFF_CLK_MODE_A = 8'h10;
    localparam logic [7:0] OFF_CLK_MODE_B = 8'h14;
    localparam logic [7:0] OFF_TXBC_HI_A  = 8'h18;
    localparam logic [7:0] OFF_TXBC_HI_B  = 8'h1c;
    localparam logic [7:0] OFF_VER_STATUS = 8'h20;

    localparam int IRQ_RX_BLOCK   = 0;
    localparam int IRQ_TX_SPACE   = 2;
    localparam int IRQ_CD_CHANGE  = 4;
    localparam int IRQ_FRAME_SYNC = 6;
    localparam int EXT_RX_OVF     = 0;
    localparam int EXT_TX_OVF     = 2;

    localparam int MODE_LSB       = 0;
    localparam int BLK_SEL_LSB    = 3;
    localparam int AUTO_START_BIT = 7;
    localparam int VS_LEVEL       = 0;
    localparam int VS_RX_EN       = 2;
    localparam int VS_VERSION_LSB = 4;

    localparam logic [7:0] MASK_RESET     = 8'h00;
    localparam logic [7:0] CLK_MODE_RESET = 8'h00;
    localparam logic [7:0] TXBC_HI_RESET  = 8'h00;
    localparam logic [5:0] PTR_RESET      = 6'h00;

    localparam logic [2:0] MODE_STROBE    = 3'h1;
    localparam logic [2:0] MODE_XTAL      = 3'h4;
    localparam logic [2:0] MODE_FSYNC     = 3'h5;
    localparam logic [2:0] MODE_XTAL_BRG  = 3'h6;
    localparam logic [2:0] MODE_XTAL_DPLL = 3'h7;

    localparam int PIN_CHAN_BIT = 6;
    localparam int PIN_WIN_BIT  = 5;
endpackage : hp_pkg

// File: logic/chan_fifo_port.sv
`timescale 1ns/100ps
// One serial channel: byte stores, DMA requests and alternate clock pin decode.
module chan_fifo_port
#(
    parameter bit IS_CHAN_A = 1'b1
)
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [2:0] clock_mode,
    input  wire logic [1:0] block_sel,
    input  wire logic       auto_start,
    input  wire logic       alt_clock_input,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    output logic [7:0]      tx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    input  wire logic       pop,
    input  wire logic       push,
    input  wire logic [7:0] push_data,
    output logic [7:0]      rx_head,
    output logic            rx_dma_request,
    output logic            tx_dma_request,
    output logic            cd_level,
    output logic            rx_enabled,
    output logic            xtal_osc,
    output logic [5:0]      events
);
    logic [7:0]              rx_mem [hp_pkg::FIFO_DEPTH];
    logic [7:0]              tx_mem [hp_pkg::FIFO_DEPTH];
    logic [hp_pkg::PTR_W-1:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
    logic [hp_pkg::PTR_W-1:0] rx_left_r, tx_left_r, rx_cnt, tx_free, blk;
    logic                     alt_q_r, is_xtal, cd_mode, rx_push, rx_pop, tx_push, tx_pop;
    logic                     rx_full, tx_full, rx_arm, tx_arm;
    logic                     primed_r;

    assign blk     = hp_pkg::PTR_W'(hp_pkg::FIFO_DEPTH >> block_sel);
    assign rx_cnt  = rx_wp_r - rx_rp_r;
    assign tx_free = hp_pkg::PTR_W'(hp_pkg::FIFO_DEPTH) - (tx_wp_r - tx_rp_r);
    assign rx_full = rx_cnt == hp_pkg::PTR_W'(hp_pkg::FIFO_DEPTH);
    assign tx_full = tx_free == hp_pkg::PTR_RESET;
    assign is_xtal = IS_CHAN_A && (clock_mode == hp_pkg::MODE_XTAL || clock_mode == hp_pkg::MODE_XTAL_BRG
                                   || clock_mode == hp_pkg::MODE_XTAL_DPLL);
    assign cd_mode = !is_xtal && clock_mode != hp_pkg::MODE_STROBE && clock_mode != hp_pkg::MODE_FSYNC;
    assign rx_enabled = (clock_mode == hp_pkg::MODE_STROBE || (auto_start && cd_mode)) ? alt_clock_input : 1'b1;
    assign rx_ready   = rx_enabled && !rx_full;
    assign rx_push    = rx_valid && rx_ready;
    assign rx_pop     = pop && rx_cnt != hp_pkg::PTR_RESET;
    assign rx_head    = rx_mem[rx_rp_r[hp_pkg::IDX_W-1:0]];
    assign tx_valid   = tx_free != hp_pkg::PTR_W'(hp_pkg::FIFO_DEPTH);
    assign tx_data    = tx_mem[tx_rp_r[hp_pkg::IDX_W-1:0]];
    assign tx_pop     = tx_valid && tx_ready;
    assign tx_push    = push && !tx_full;
    assign rx_arm     = !rx_dma_request && rx_cnt >= blk;
    assign tx_arm     = !tx_dma_request && tx_free >= blk;

    // The stores hold no reset so they map onto plain memory.
    always_ff @(posedge mclk)
    begin
        if (rx_push)
            rx_mem[rx_wp_r[hp_pkg::IDX_W-1:0]] <= rx_data;
        if (tx_push)
            tx_mem[tx_wp_r[hp_pkg::IDX_W-1:0]] <= push_data;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_wp_r <= hp_pkg::PTR_RESET;
            rx_rp_r <= hp_pkg::PTR_RESET;
            tx_wp_r <= hp_pkg::PTR_RESET;
            tx_rp_r <= hp_pkg::PTR_RESET;
        end
        else
        begin
            rx_wp_r <= rx_wp_r + hp_pkg::PTR_W'(rx_push);
            rx_rp_r <= rx_rp_r + hp_pkg::PTR_W'(rx_pop);
            tx_wp_r <= tx_wp_r + hp_pkg::PTR_W'(tx_push);
            tx_rp_r <= tx_rp_r + hp_pkg::PTR_W'(tx_pop);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_dma_request <= 1'b0;
            rx_left_r      <= hp_pkg::PTR_RESET;
        end
        else if (rx_arm)
        begin
            rx_dma_request <= 1'b1;
            rx_left_r      <= blk;
        end
        else if (rx_dma_request && rx_pop)
        begin
            rx_left_r <= rx_left_r - hp_pkg::PTR_W'(1);
            if (rx_left_r == hp_pkg::PTR_W'(1))
                rx_dma_request <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_dma_request <= 1'b0;
            tx_left_r      <= hp_pkg::PTR_RESET;
        end
        else if (tx_arm)
        begin
            tx_dma_request <= 1'b1;
            tx_left_r      <= blk;
        end
        else if (tx_dma_request && tx_push)
        begin
            tx_left_r <= tx_left_r - hp_pkg::PTR_W'(1);
            if (tx_left_r == hp_pkg::PTR_W'(1))
                tx_dma_request <= 1'b0;
        end
    end

    // Events: rx block, tx space, cd change, frame sync, rx overflow, tx overflow.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            alt_q_r  <= 1'b0;
            primed_r <= 1'b0;
            cd_level <= 1'b0;
            xtal_osc <= 1'b0;
            events   <= 6'h00;
        end
        else
        begin
            alt_q_r   <= alt_clock_input;
            // The pin has no known idle level, so edges are ignored until one real sample is held.
            primed_r  <= 1'b1;
            cd_level  <= cd_mode && alt_clock_input;
            xtal_osc  <= is_xtal;
            events[0] <= rx_arm;
            events[1] <= tx_arm;
            events[2] <= primed_r && cd_mode && alt_clock_input != alt_q_r;
            events[3] <= primed_r && clock_mode == hp_pkg::MODE_FSYNC && alt_clock_input && !alt_q_r;
            events[4] <= rx_valid && rx_enabled && rx_full;
            events[5] <= push && tx_full;
        end
    end
endmodule : chan_fifo_port

// File: test/serial_host_pins_properties.sv
// Port-level properties of the host pin block.
`timescale 1ns/100ps
module serial_host_pins_properties
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        irq,
    input wire logic        int_req_n_out,
    input wire logic        int_req_n_oe,
    input wire logic        host_rd_n,
    input wire logic        host_data_oe,
    input wire logic        dma_grant_n_chan_a,
    input wire logic        dma_grant_n_chan_b,
    input wire logic [1:0]  rx_dma_request,
    input wire logic [1:0]  xtal_osc_en
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // A write counts from the edge at which waitrequest is seen low.
    wire wr_done = avs_write & ~avs_waitrequest;

    sequence s_wait;
        (avs_read | avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest;
    endsequence
    sequence s_rd_ack;
        s_wait ##1 (s_ack and avs_read);
    endsequence

    a_one_wait: assert property (s_wait |=> s_ack) else $error("waitrequest held too long");
    a_read_upper: assert property (s_rd_ack |-> avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
    a_oe_is_irq: assert property (int_req_n_oe == irq) else $error("irq pin enable differs from irq");
    a_pin_only_low: assert property (int_req_n_oe |-> !int_req_n_out) else $error("irq pin drives high");
    a_irq_held: assert property ($fell(irq) |-> $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3))
        else $error("irq released without host write");
    a_oe_needs_rd: assert property (host_data_oe |-> !host_rd_n) else $error("data driven without read");
    a_grant_selects: assert property ((!dma_grant_n_chan_a || !dma_grant_n_chan_b) && !host_rd_n |-> host_data_oe)
        else $error("granted read not driven");
    a_xtal_b_off: assert property (xtal_osc_en[1] == 1'b0) else $error("channel b oscillator enabled");
    a_rx_req_drop: assert property ($fell(rx_dma_request[0]) |-> !$past(host_rd_n))
        else $error("receive request dropped without read");
endmodule : serial_host_pins_properties

bind serial_host_pins serial_host_pins_properties u_props
(
    .mclk, .rst, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .irq, .int_req_n_out, .int_req_n_oe,
    .host_rd_n, .host_data_oe, .dma_grant_n_chan_a, .dma_grant_n_chan_b, .rx_dma_request, .xtal_osc_en
);

// File: test/host_dma_model.sv
// DMA controller model driving the parallel pin side.
`timescale 1ns/100ps
module host_dma_model
(
    input  wire logic       mclk,
    input  wire logic [1:0] rx_dma_request,
    input  wire logic [1:0] tx_dma_request,
    input  wire logic [7:0] host_data_out,
    output logic            dma_grant_n_chan_a,
    output logic            dma_grant_n_chan_b,
    output logic            host_rd_n,
    output logic            host_wr_n,
    output logic [7:0]      host_data_in
);
    logic [1:0] grant_n;

    assign dma_grant_n_chan_a = grant_n[0];
    assign dma_grant_n_chan_b = grant_n[1];

    initial
    begin
        grant_n = 2'b11;
        host_rd_n = 1'b1;
        host_wr_n = 1'b1;
        host_data_in = 8'h00;
    end

    task automatic dma_read(input bit ch, output logic [7:0] b);
        // Let an edge pass so a grant released by the previous call is seen high.
        @(posedge mclk);
        while (rx_dma_request[ch] !== 1'b1)
            @(posedge mclk);
        grant_n[ch] <= 1'b0;
        @(posedge mclk);
        host_rd_n <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        b = host_data_out;
        host_rd_n <= 1'b1;
        @(posedge mclk);
        grant_n[ch] <= 1'b1;
    endtask : dma_read

    task automatic dma_write(input bit ch, input logic [7:0] d);
        @(posedge mclk);
        while (tx_dma_request[ch] !== 1'b1)
            @(posedge mclk);
        grant_n[ch] <= 1'b0;
        host_wr_n <= 1'b0;
        host_data_in <= d;
        @(posedge mclk);
        host_wr_n <= 1'b1;
        @(posedge mclk);
        @(posedge mclk);
        grant_n[ch] <= 1'b1;
        // A released bus shows the inverse so stale data cannot pass.
        host_data_in <= ~d;
    endtask : dma_write
endmodule : host_dma_model

// File: test/tb_serial_host_pins.sv
// Self-checking bench for the host pin block.
`timescale 1ns/100ps
module tb_serial_host_pins;
    localparam logic [3:0] VC = 4'h9; // Arbitrary version code.
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, irq, int_req_n_out, int_req_n_oe, host_data_oe;
    logic        host_rd_n, host_wr_n, dma_grant_n_chan_a, dma_grant_n_chan_b;
    logic [7:0]  host_data_in, host_data_out, r;
    logic [1:0]  alt_clock_input = 2'b10;
    logic [1:0]  rx_dma_request, tx_dma_request, xtal_osc_en, rx_ready, tx_valid;
    logic [15:0] rx_data = 16'h0;
    logic [15:0] tx_data;
    logic [1:0]  rx_valid = 2'b00;
    logic [1:0]  tx_ready = 2'b00;
    logic [2:0]  modes [4] = '{hp_pkg::MODE_XTAL, hp_pkg::MODE_XTAL_BRG, hp_pkg::MODE_XTAL_DPLL, 3'h0};
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;
    int          i;

    // The pin address points outside the FIFO window, so only a grant can reach a FIFO.
    serial_host_pins #(.VERSION_CODE(VC)) dut
    (
        .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .irq, .int_req_n_out, .int_req_n_oe, .host_addr(7'h20), .host_cs_n(1'b1),
        .host_rd_n, .host_wr_n, .host_data_in, .host_data_out, .host_data_oe, .dma_grant_n_chan_a,
        .dma_grant_n_chan_b, .alt_clock_input, .rx_dma_request, .tx_dma_request, .xtal_osc_en,
        .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready
    );

    host_dma_model host
    (
        .mclk, .rx_dma_request, .tx_dma_request, .host_data_out, .dma_grant_n_chan_a,
        .dma_grant_n_chan_b, .host_rd_n, .host_wr_n, .host_data_in
    );

    always #10 mclk = ~mclk;

    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic wait_cy(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cy

    task automatic av_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        avs_write <= 1'b0;
    endtask : av_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        chk(r & m, e);
    endtask : rd_chk

    task automatic rx_send(input logic [7:0] b);
        @(posedge mclk);
        rx_data[7:0] <= b;
        rx_valid[0] <= 1'b1;
        @(posedge mclk);
        while (rx_ready[0] !== 1'b1)
            @(posedge mclk);
        rx_valid[0] <= 1'b0;
    endtask : rx_send

    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 6; i++)
            rd_chk(8'(8'h04 + 4 * i), 8'hff, 8'h00);
        rd_chk(8'h20, 8'hff, {VC, 4'he});
        rd_chk(8'h24, 8'hff, 8'h00);
        av_wr(8'h20, 8'hff, 4'hf);
        rd_chk(8'h20, 8'hff, {VC, 4'he});
        av_wr(8'h04, 8'hff, 4'h0);
        rd_chk(8'h04, 8'hff, 8'h00);
        // Four-byte blocks keep the receive run short.
        av_wr(8'h10, 8'h18, 4'hf);
        av_wr(8'h04, 8'h01, 4'hf);
        for (i = 0; i < 4; i++)
            rx_send(8'(8'ha0 + i));
        wait_cy(6);
        chk({7'h0, irq}, 8'h01);
        chk({7'h0, int_req_n_oe}, 8'h01);
        for (i = 0; i < 4; i++)
        begin
            chk({7'h0, rx_dma_request[0]}, 8'h01);
            host.dma_read(1'b0, r);
            chk(r, 8'(8'ha0 + i));
        end
        chk({7'h0, rx_dma_request[0]}, 8'h00);
        rd_chk(8'h00, 8'h01, 8'h01);
        av_wr(8'h00, 8'h01, 4'hf);
        wait_cy(4);
        chk({7'h0, irq}, 8'h00);
        rd_chk(8'h00, 8'h01, 8'h00);
        av_wr(8'h10, {5'h0, hp_pkg::MODE_STROBE}, 4'hf);
        wait_cy(2);
        chk({7'h0, rx_ready[0]}, 8'h00);
        alt_clock_input[0] <= 1'b1;
        wait_cy(3);
        chk({7'h0, rx_ready[0]}, 8'h01);
        av_wr(8'h10, 8'h00, 4'hf);
        av_wr(8'h18, 8'h80, 4'hf);
        alt_clock_input[0] <= 1'b0;
        wait_cy(3);
        chk({7'h0, rx_ready[0]}, 8'h00);
        rd_chk(8'h20, 8'hff, {VC, 4'ha});
        av_wr(8'h18, 8'h00, 4'hf);
        av_wr(8'h14, {5'h0, hp_pkg::MODE_FSYNC}, 4'hf);
        alt_clock_input[1] <= 1'b0;
        wait_cy(3);
        av_wr(8'h00, 8'h80, 4'hf);
        alt_clock_input[1] <= 1'b1;
        wait_cy(4);
        rd_chk(8'h00, 8'h80, 8'h80);
        for (i = 0; i < 4; i++)
        begin
            av_wr(8'h10, {5'h0, modes[i]}, 4'hf);
            wait_cy(3);
            chk({6'h0, xtal_osc_en}, (modes[i] == 3'h0) ? 8'h00 : 8'h01);
        end
        host.dma_write(1'b1, 8'h5c);
        wait_cy(2);
        chk({7'h0, tx_valid[1]}, 8'h01);
        chk(tx_data[15:8], 8'h5c);
        tx_ready[1] <= 1'b1;
        wait_cy(1);
        tx_ready[1] <= 1'b0;
        wait_cy(1);
        chk({7'h0, tx_valid[1]}, 8'h00);
        tally_and_finish();
    end
endmodule : tb_serial_host_pins
